// file: dv/data_mem_model.sv
// Purpose: Behavioural data memory on the far side of the execute-stage control
// Assumes: Address and data latched at the send pulse; strobes come one cycle later
// Notes:   Only 64 words decoded from address bits 7:2; aliases above that
`timescale 1ns/1ps
module data_mem_model
  import exec_timing_pkg::*;
#(
  parameter logic [DW-1:0] INIT_BASE = 32'h0
) (
  input  wire logic                  clk_i,
  input  wire logic [NSLOT-1:0]      req_i,
  input  wire logic [NSLOT*AW-1:0]   addr_i,
  input  wire logic [NSLOT*DW-1:0]   wdata_i,
  input  wire logic [NSLOT-1:0]      rd_i,
  input  wire logic [NSLOT-1:0]      wr_i,
  output logic      [NSLOT*DW-1:0]   rdata_o
);
  logic [DW-1:0] mem      [64];
  logic [AW-1:0] lat_addr [NSLOT];
  logic [DW-1:0] lat_wd   [NSLOT];

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = INIT_BASE + DW'(i);
    end
    rdata_o = '0;
  end

  always @(posedge clk_i) begin
    // Reads sample the array before any write of the same edge
    for (int s = 0; s < NSLOT; s++) begin
      if (rd_i[s]) begin
        rdata_o[s*DW +: DW] <= mem[lat_addr[s][7:2]];
      end else begin
        // Stale word inverted so a late capture cannot pass by luck
        rdata_o[s*DW +: DW] <= ~rdata_o[s*DW +: DW];
      end
    end
    for (int s = 0; s < NSLOT; s++) begin
      if (wr_i[s]) begin
        mem[lat_addr[s][7:2]] = lat_wd[s];
      end
    end
    // Latch last, so a back-to-back send does not steal the older strobe's address
    for (int s = 0; s < NSLOT; s++) begin
      if (req_i[s]) begin
        lat_addr[s] = addr_i[s*AW +: AW];
        lat_wd[s]   = wdata_i[s*DW +: DW];
      end
    end
  end
endmodule // data_mem_model

// file: dv/dsp_pipeline_exec_timing_bench.sv
// Purpose: Self-checking bench for the execute-stage timing control
// Assumes: One packet per cycle, operands one cycle after their packet
// Notes:   Expected phase flags derived per class and cycle offset
`timescale 1ns/1ps
module dsp_pipeline_exec_timing_bench;
  import exec_timing_pkg::*;
  localparam logic [DW-1:0] INIT_BASE = 32'h5a00_0000;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [NSLOT-1:0] dc_valid = '0, dc_cond = '0, dc_ptr_mod = '0, op_sat = '0;
  instr_class_t dc_class [NSLOT] = '{CLS_NOP, CLS_NOP};
  instr_class_t s_class  [NSLOT] = '{CLS_NOP, CLS_NOP};
  logic [NSLOT*RW-1:0] dc_dst = '0, dc_ptr = '0, s_dst = '0, s_ptr = '0;
  logic [NSLOT*AW-1:0] op_addr = '0, s_addr = '0, p_addr = '0, mem_addr;
  logic [NSLOT*DW-1:0] op_wdata = '0, s_wd = '0, p_wd = '0, mem_rdata, mem_wdata, wb5_wd;
  logic [NSLOT-1:0] s_valid = '0, s_cond = '0, s_mod = '0, s_sat = '0, p_sat = '0;
  logic [NSLOT-1:0] wb1_we, ptr_we, wb2_we, mem_req, mem_we, mem_rd, mem_wr, wb5_we;
  logic [NSLOT*RW-1:0] wb1_wa, ptr_wa, wb2_wa, wb5_wa;
  logic sat_set, br_fetch, br_target;
  logic [NREG-1:0] busy;
  int n_errors = 0, n_tests = 0;

  always #25 clk = ~clk;

  exec_timing_ctrl dut (.CLK_I(clk), .NRST_I(rst_n), .DC_VALID_I(dc_valid), .DC_COND_I(dc_cond),
    .DC_CLASS_I(dc_class), .DC_DST_I(dc_dst), .DC_PTR_I(dc_ptr), .DC_PTR_MOD_I(dc_ptr_mod),
    .OP_SAT_I(op_sat), .OP_ADDR_I(op_addr), .OP_WDATA_I(op_wdata), .MEM_RDATA_I(mem_rdata),
    .WB1_WE_O(wb1_we), .WB1_WA_O(wb1_wa), .PTR_WE_O(ptr_we), .PTR_WA_O(ptr_wa),
    .WB2_WE_O(wb2_we), .WB2_WA_O(wb2_wa), .SAT_SET_O(sat_set), .MEM_REQ_O(mem_req),
    .MEM_WE_O(mem_we), .MEM_ADDR_O(mem_addr), .MEM_WDATA_O(mem_wdata), .MEM_RD_O(mem_rd),
    .MEM_WR_O(mem_wr), .WB5_WE_O(wb5_we), .WB5_WA_O(wb5_wa), .WB5_WD_O(wb5_wd),
    .BR_FETCH_O(br_fetch), .BR_TARGET_O(br_target), .BUSY_O(busy));

  data_mem_model #(.INIT_BASE(INIT_BASE)) mem_u (.clk_i(clk), .req_i(mem_req),
    .addr_i(mem_addr), .wdata_i(mem_wdata), .rd_i(mem_rd), .wr_i(mem_wr), .rdata_o(mem_rdata));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Every input changes once, 1 ns after the edge; operands trail their packet
  task automatic tick;
    @(posedge clk);
    #1;
    dc_valid = s_valid; dc_cond = s_cond; dc_ptr_mod = s_mod; dc_class = s_class;
    dc_dst = s_dst; dc_ptr = s_ptr;
    op_sat = p_sat; op_addr = p_addr; op_wdata = p_wd;
    p_sat = s_sat; p_addr = s_addr; p_wd = s_wd;
    s_valid = '0; s_sat = '0;
  endtask

  task automatic issue(input int s, input instr_class_t c, input logic cnd,
                       input logic [RW-1:0] d, input logic [AW-1:0] a, input logic [DW-1:0] w);
    s_valid[s] = 1'b1; s_cond[s] = cnd; s_class[s] = c; s_mod[s] = 1'b1;
    s_dst[s*RW +: RW] = d; s_ptr[s*RW +: RW] = d + 5'h1;
    s_sat[s] = (c == CLS_SINGLE); s_addr[s*AW +: AW] = a; s_wd[s*DW +: DW] = w;
  endtask

  task automatic run_one(input int s, input instr_class_t c, input logic cnd);
    logic [RW-1:0] d;
    logic [AW-1:0] a;
    logic [10:0] exp, seen;
    logic ls;
    d = RW'(8*s + c + 2);
    a = AW'((8*s + c) * 4);
    ls = cnd && (c == CLS_LOAD || c == CLS_STORE);
    issue(s, c, cnd, d, a, 32'hd0d0_0000 + a);
    tick;
    for (int k = 0; k < 8; k++) begin
      tick;
      exp = {cnd && c == CLS_SINGLE && k == 0, ls && k == 0, cnd && c == CLS_MULT && k == 1,
             ls && k == 1, cnd && c == CLS_LOAD && k == 2, cnd && c == CLS_STORE && k == 2,
             cnd && c == CLS_LOAD && k == 4, cnd && c == CLS_BRANCH && k == 0,
             cnd && c == CLS_BRANCH && k == 6, cnd && c == CLS_SINGLE && k == 1,
             cnd && ((c == CLS_MULT && k == 1) || (c == CLS_LOAD && k >= 1 && k <= 4))};
      seen = {wb1_we[s], ptr_we[s], wb2_we[s], mem_req[s], mem_rd[s], mem_wr[s], wb5_we[s],
              br_fetch, br_target, sat_set, busy[d]};
      check("phase flags", 64'(seen), 64'(exp));
      if (ls && k == 0) check("pointer addr", 64'(ptr_wa[s*RW +: RW]), 64'(d + 5'h1));
      if (cnd && c == CLS_SINGLE && k == 0) check("wb1 addr", 64'(wb1_wa[s*RW +: RW]), 64'(d));
      if (ls && k == 1) check("mem send", 64'({mem_we[s], mem_addr[s*AW +: AW]}),
                              64'({c == CLS_STORE, a}));
      if (cnd && c == CLS_LOAD && k == 4) check("load write", 64'({wb5_wa[s*RW +: RW],
          wb5_wd[s*DW +: DW]}), 64'({d, INIT_BASE + DW'(a[7:2])}));
    end
  endtask

  task automatic t_classes;
    for (int s = 0; s < NSLOT; s++)
      for (int c = 0; c < 6; c++)
        for (int t = 0; t < 2; t++) run_one(s, instr_class_t'(c), t[0]);
  endtask

  task automatic t_order(input logic st_first, input logic par);
    logic [AW-1:0] a;
    logic [DW-1:0] w;
    int ls;
    a = 32'h80 + AW'({st_first, par}) * 4;
    w = 32'hfeed_0000 + a;
    ls = par ? 1 : 0;
    if (par || st_first) issue(0, CLS_STORE, 1'b1, 5'h3, a, w);
    else issue(0, CLS_LOAD, 1'b1, 5'h4, a, '0);
    if (par) issue(1, CLS_LOAD, 1'b1, 5'h4, a, '0);
    tick;
    if (!par) begin
      if (st_first) issue(0, CLS_LOAD, 1'b1, 5'h4, a, '0);
      else issue(0, CLS_STORE, 1'b1, 5'h3, a, w);
      tick;
    end
    repeat ((par || st_first) ? 5 : 4) tick;
    check("load order", 64'({wb5_we[ls], wb5_wd[ls*DW +: DW]}), 64'({1'b1,
          (st_first && !par) ? w : INIT_BASE + DW'(a[7:2])}));
    repeat (4) tick;
  endtask

  task automatic t_overlap;
    issue(0, CLS_MULT, 1'b1, 5'h9, '0, '0);
    issue(1, CLS_SINGLE, 1'b1, 5'ha, '0, '0);
    repeat (3) tick;
    check("overlap busy", 64'({busy[9], busy[10], wb2_we[0]}), 64'h5);
    tick;
    check("mult released", 64'(busy[9]), 64'h0);
  endtask

  task automatic t_branch_restart;
    issue(0, CLS_BRANCH, 1'b1, 5'h1, '0, '0);
    repeat (2) tick;
    issue(1, CLS_BRANCH, 1'b1, 5'h1, '0, '0);
    tick;
    for (int i = 1; i < 10; i++) begin
      tick;
      check("branch target", 64'(br_target), 64'(i == 7));
    end
  endtask

  initial begin
    #(50 * 20000);
    n_errors++;
    print_verdict;
  end

  initial begin
    repeat (20) @(posedge clk);
    check("reset quiet", 64'({wb1_we, ptr_we, wb2_we, mem_req, mem_rd, mem_wr, wb5_we,
          br_fetch, br_target, sat_set, busy}), 64'h0);
    #1;
    rst_n = 1'b1;
    repeat (3) tick;
    t_classes;
    for (int m = 0; m < 3; m++) t_order(m[0], m[1]);
    t_overlap;
    t_branch_restart;
    print_verdict;
  end
endmodule // dsp_pipeline_exec_timing_bench

// file: rtl/exec_phase_track.sv
// Purpose: Phase tracker for one issue slot, execute phases one to four
// Assumes: A false condition is known when the packet leaves decode
// Notes:   Cancelled instructions travel on as no-operations
`timescale 1ns/1ps
module exec_phase_track (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         dc_live_i,
  input  exec_timing_pkg::instr_class_t     dc_class_i,
  input  wire logic [exec_timing_pkg::RW-1:0] dc_dst_i,
  output exec_timing_pkg::instr_class_t     cls_o [exec_timing_pkg::NSTG],
  output logic [exec_timing_pkg::RW-1:0]    dst_o [exec_timing_pkg::NSTG]
);
  import exec_timing_pkg::*;

  instr_class_t     cls_r [NSTG];
  logic [RW-1:0]    dst_r [NSTG];
  instr_class_t     live_cls;

  // Killed instruction does nothing from the first phase on
  assign live_cls = dc_live_i ? dc_class_i : CLS_NOP;

  // Whole group moves one phase per clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < NSTG; k++) begin
        cls_r[k] <= CLS_NOP;
        dst_r[k] <= '0;
      end
    end else begin
      cls_r[PH_ONE] <= live_cls;
      dst_r[PH_ONE] <= dc_dst_i;
      for (int k = 1; k < NSTG; k++) begin
        cls_r[k] <= cls_r[k-1];
        dst_r[k] <= dst_r[k-1];
      end
    end
  end

  assign cls_o = cls_r;
  assign dst_o = dst_r;
endmodule // exec_phase_track

// file: rtl/exec_timing_ctrl.sv
// Purpose: Execute-stage timing control for a two-slot VLIW pipeline
// Assumes: Packet inputs arrive in the decode phase; operand inputs in
//          the first execute phase; read data returns in phase four
// Notes:   Every output is a flop decoded one phase ahead
`timescale 1ns/1ps
module exec_timing_ctrl (
  input  wire logic                                     CLK_I,
  input  wire logic                                     NRST_I,
  input  wire logic [exec_timing_pkg::NSLOT-1:0]        DC_VALID_I,
  input  wire logic [exec_timing_pkg::NSLOT-1:0]        DC_COND_I,
  input  exec_timing_pkg::instr_class_t                 DC_CLASS_I [exec_timing_pkg::NSLOT],
  input  wire logic [exec_timing_pkg::NSLOT*exec_timing_pkg::RW-1:0] DC_DST_I,
  input  wire logic [exec_timing_pkg::NSLOT*exec_timing_pkg::RW-1:0] DC_PTR_I,
  input  wire logic [exec_timing_pkg::NSLOT-1:0]        DC_PTR_MOD_I,
  input  wire logic [exec_timing_pkg::NSLOT-1:0]        OP_SAT_I,
  input  wire logic [exec_timing_pkg::NSLOT*exec_timing_pkg::AW-1:0] OP_ADDR_I,
  input  wire logic [exec_timing_pkg::NSLOT*exec_timing_pkg::DW-1:0] OP_WDATA_I,
  input  wire logic [exec_timing_pkg::NSLOT*exec_timing_pkg::DW-1:0] MEM_RDATA_I,
  output logic [exec_timing_pkg::NSLOT-1:0]             WB1_WE_O,
  output logic [exec_timing_pkg::NSLOT*exec_timing_pkg::RW-1:0] WB1_WA_O,
  output logic [exec_timing_pkg::NSLOT-1:0]             PTR_WE_O,
  output logic [exec_timing_pkg::NSLOT*exec_timing_pkg::RW-1:0] PTR_WA_O,
  output logic [exec_timing_pkg::NSLOT-1:0]             WB2_WE_O,
  output logic [exec_timing_pkg::NSLOT*exec_timing_pkg::RW-1:0] WB2_WA_O,
  output logic                                          SAT_SET_O,
  output logic [exec_timing_pkg::NSLOT-1:0]             MEM_REQ_O,
  output logic [exec_timing_pkg::NSLOT-1:0]             MEM_WE_O,
  output logic [exec_timing_pkg::NSLOT*exec_timing_pkg::AW-1:0] MEM_ADDR_O,
  output logic [exec_timing_pkg::NSLOT*exec_timing_pkg::DW-1:0] MEM_WDATA_O,
  output logic [exec_timing_pkg::NSLOT-1:0]             MEM_RD_O,
  output logic [exec_timing_pkg::NSLOT-1:0]             MEM_WR_O,
  output logic [exec_timing_pkg::NSLOT-1:0]             WB5_WE_O,
  output logic [exec_timing_pkg::NSLOT*exec_timing_pkg::RW-1:0] WB5_WA_O,
  output logic [exec_timing_pkg::NSLOT*exec_timing_pkg::DW-1:0] WB5_WD_O,
  output logic                                          BR_FETCH_O,
  output logic                                          BR_TARGET_O,
  output logic [exec_timing_pkg::NREG-1:0]              BUSY_O
);
  import exec_timing_pkg::*;

  logic                 rst_meta_r;
  logic                 rst_n;
  logic [NSLOT-1:0]     dc_live;
  logic [NSLOT-1:0]     wb1_we_nxt;
  logic [NSLOT-1:0]     ptr_we_nxt;
  logic [NSLOT-1:0]     wb2_we_nxt;
  logic [NSLOT*RW-1:0]  wb2_wa_nxt;
  logic [NSLOT-1:0]     sat_hit;
  logic [NSLOT-1:0]     mem_req_nxt;
  logic [NSLOT-1:0]     mem_we_nxt;
  logic [NSLOT-1:0]     mem_rd_nxt;
  logic [NSLOT-1:0]     mem_wr_nxt;
  logic [NSLOT-1:0]     wb5_we_nxt;
  logic [NSLOT*RW-1:0]  wb5_wa_nxt;
  logic [NSLOT-1:0]     br_hit;
  logic                 br_fetch_nxt;
  logic                 br_target_nxt;
  logic [NREG-1:0]      busy_nxt;
  br_state_t            br_state_r;
  br_state_t            br_state_nxt;
  logic [BR_CW-1:0]     br_cnt_r;
  logic [BR_CW-1:0]     br_cnt_nxt;
  instr_class_t         cls_s [NSLOT][NSTG];
  logic [RW-1:0]        dst_s [NSLOT][NSTG];

  // Reset released through two flops; the rest runs on the clean copy
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    exec_phase_track u_track (
      .clk_i      (CLK_I),
      .rst_n_i    (rst_n),
      .dc_live_i  (dc_live[s]),
      .dc_class_i (DC_CLASS_I[s]),
      .dc_dst_i   (DC_DST_I[s*RW +: RW]),
      .cls_o      (cls_s[s]),
      .dst_o      (dst_s[s])
    );

    // Condition resolved before any later-phase work
    assign dc_live[s]     = DC_VALID_I[s] & DC_COND_I[s];
    assign wb1_we_nxt[s]  = dc_live[s] & (DC_CLASS_I[s] == CLS_SINGLE);
    assign ptr_we_nxt[s]  = dc_live[s] & DC_PTR_MOD_I[s] &
                            ((DC_CLASS_I[s] == CLS_LOAD) ||
                             (DC_CLASS_I[s] == CLS_STORE));
    assign br_hit[s]      = dc_live[s] & (DC_CLASS_I[s] == CLS_BRANCH);
    assign wb2_we_nxt[s]  = (cls_s[s][PH_ONE] == CLS_MULT);
    assign wb2_wa_nxt[s*RW +: RW] = dst_s[s][PH_ONE];
    assign sat_hit[s]     = OP_SAT_I[s] & (cls_s[s][PH_ONE] == CLS_SINGLE);
    assign mem_req_nxt[s] = (cls_s[s][PH_ONE] == CLS_LOAD) ||
                            (cls_s[s][PH_ONE] == CLS_STORE);
    assign mem_we_nxt[s]  = (cls_s[s][PH_ONE] == CLS_STORE);
    assign mem_rd_nxt[s]  = (cls_s[s][PH_TWO] == CLS_LOAD);
    assign mem_wr_nxt[s]  = (cls_s[s][PH_TWO] == CLS_STORE);
    assign wb5_we_nxt[s]  = (cls_s[s][PH_FOUR] == CLS_LOAD);
    assign wb5_wa_nxt[s*RW +: RW] = dst_s[s][PH_FOUR];

    sequence single_in_dc;
      dc_live[s] && (DC_CLASS_I[s] == CLS_SINGLE);
    endsequence
    single_wb_a: assert property (single_in_dc |=> WB1_WE_O[s] &&
      (WB1_WA_O[s*RW +: RW] == $past(DC_DST_I[s*RW +: RW])))
      else $error("single-cycle write missing in phase one");

    mult_wb_a: assert property ((cls_s[s][PH_ONE] == CLS_MULT) |=>
      WB2_WE_O[s] && BUSY_O[WB2_WA_O[s*RW +: RW]])
      else $error("multiply write missing in phase two");

    sequence store_steps;
      MEM_REQ_O[s] && MEM_WE_O[s] ##1 MEM_WR_O[s] && !MEM_RD_O[s];
    endsequence
    store_phase_a: assert property ((cls_s[s][PH_ONE] == CLS_STORE) |=>
      store_steps)
      else $error("store phases out of order");

    sequence load_steps;
      MEM_REQ_O[s] && !MEM_WE_O[s] ##1 MEM_RD_O[s] ##2 WB5_WE_O[s];
    endsequence
    load_phase_a: assert property ((cls_s[s][PH_ONE] == CLS_LOAD) |=>
      load_steps)
      else $error("load phases out of order");

    load_busy_a: assert property ((cls_s[s][PH_ONE] == CLS_LOAD) |=>
      BUSY_O[dst_s[s][PH_TWO]] ##1 BUSY_O[dst_s[s][PH_THREE]]
      ##1 BUSY_O[dst_s[s][PH_FOUR]] ##1 BUSY_O[WB5_WA_O[s*RW +: RW]])
      else $error("loaded register visible inside delay slots");

    ptr_upd_a: assert property (PTR_WE_O[s] |->
      (cls_s[s][PH_ONE] == CLS_LOAD) || (cls_s[s][PH_ONE] == CLS_STORE))
      else $error("pointer write outside load or store phase one");

    cond_kill_a: assert property (DC_VALID_I[s] && !DC_COND_I[s] |=>
      !WB1_WE_O[s] && !PTR_WE_O[s] ##1 !MEM_REQ_O[s] && !WB2_WE_O[s])
      else $error("false condition still acted");

    nop_quiet_a: assert property (DC_CLASS_I[s] == CLS_NOP |=>
      !WB1_WE_O[s] && !PTR_WE_O[s] ##1 !MEM_REQ_O[s] && !WB2_WE_O[s]
      ##1 !MEM_RD_O[s] && !MEM_WR_O[s] ##2 !WB5_WE_O[s])
      else $error("no-operation caused activity");

    phase_step_a: assert property (1'b1 |=>
      cls_s[s][PH_THREE] == $past(cls_s[s][PH_TWO]))
      else $error("phase did not advance by one");

    sat_flag_a: assert property (sat_hit[s] |=> SAT_SET_O)
      else $error("saturation flag not set in phase two");
  end

  // Same-location ordering falls out of strict program order in phase three
  sequence load_then_store;
    (cls_s[0][PH_ONE] == CLS_LOAD) ##1 (cls_s[0][PH_ONE] == CLS_STORE);
  endsequence
  ld_st_order_a: assert property (load_then_store |=>
    MEM_RD_O[0] ##1 MEM_WR_O[0])
    else $error("load did not read before following store");

  sequence store_then_load;
    (cls_s[0][PH_ONE] == CLS_STORE) ##1 (cls_s[0][PH_ONE] == CLS_LOAD);
  endsequence
  st_ld_order_a: assert property (store_then_load |=>
    MEM_WR_O[0] ##1 MEM_RD_O[0])
    else $error("store did not write before following load");

  par_access_a: assert property ((cls_s[0][PH_ONE] == CLS_STORE) &&
    (cls_s[1][PH_ONE] == CLS_LOAD) |-> ##2 MEM_WR_O[0] && MEM_RD_O[1])
    else $error("parallel store and load not in the same phase");

  // Branch target sits in fetch now; it reaches phase one after five slots
  assign br_fetch_nxt = |br_hit;

  always_comb begin
    br_state_nxt  = br_state_r;
    br_cnt_nxt    = br_cnt_r;
    br_target_nxt = 1'b0;
    case (br_state_r)
      BR_IDLE: begin
        br_cnt_nxt = BR_CNT_ZERO;
      end
      BR_DELAY: begin
        if (br_cnt_r == BR_CNT_ZERO) begin
          br_target_nxt = 1'b1;
          br_state_nxt  = BR_IDLE;
        end else begin
          br_cnt_nxt = br_cnt_r - BR_CNT_STEP;
        end
      end
      default: begin
        br_state_nxt = BR_IDLE;
        br_cnt_nxt   = BR_CNT_ZERO;
      end
    endcase
    // A later branch restarts the delay; the newest target wins
    if (br_fetch_nxt) begin
      br_state_nxt = BR_DELAY;
      br_cnt_nxt   = BR_DELAY_SLOTS;
    end
  end

  sequence branch_slots;
    BR_FETCH_O ##1 (!BR_FETCH_O) [*5];
  endsequence
  branch_tgt_a: assert property (branch_slots |=> BR_TARGET_O)
    else $error("branch target not in phase one after five slots");

  // Pending writes hide a register only; other results stay usable
  always_comb begin
    busy_nxt = '0;
    for (int s = 0; s < NSLOT; s++) begin
      if (cls_s[s][PH_ONE] == CLS_MULT || cls_s[s][PH_ONE] == CLS_LOAD) begin
        busy_nxt[dst_s[s][PH_ONE]] = 1'b1;
      end
      for (int k = PH_TWO; k < NSTG; k++) begin
        if (cls_s[s][k] == CLS_LOAD) begin
          busy_nxt[dst_s[s][k]] = 1'b1;
        end
      end
    end
  end

  busy_clear_a: assert property (WB5_WE_O[0] && !BR_FETCH_O &&
    (busy_nxt == '0) |=> (BUSY_O == '0))
    else $error("register held busy after its last delay slot");

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      br_state_r <= BR_IDLE;
      br_cnt_r   <= BR_CNT_ZERO;
    end else begin
      br_state_r <= br_state_nxt;
      br_cnt_r   <= br_cnt_nxt;
    end
  end

  // Phase one outputs
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      WB1_WE_O   <= '0;
      WB1_WA_O   <= '0;
      PTR_WE_O   <= '0;
      PTR_WA_O   <= '0;
      BR_FETCH_O <= 1'b0;
    end else begin
      WB1_WE_O   <= wb1_we_nxt;
      WB1_WA_O   <= DC_DST_I;
      PTR_WE_O   <= ptr_we_nxt;
      PTR_WA_O   <= DC_PTR_I;
      BR_FETCH_O <= br_fetch_nxt;
    end
  end

  // Phase two outputs; operands are taken while in phase one
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      WB2_WE_O    <= '0;
      WB2_WA_O    <= '0;
      SAT_SET_O   <= 1'b0;
      MEM_REQ_O   <= '0;
      MEM_WE_O    <= '0;
      MEM_ADDR_O  <= '0;
      MEM_WDATA_O <= '0;
    end else begin
      WB2_WE_O    <= wb2_we_nxt;
      WB2_WA_O    <= wb2_wa_nxt;
      SAT_SET_O   <= |sat_hit;
      MEM_REQ_O   <= mem_req_nxt;
      MEM_WE_O    <= mem_we_nxt;
      MEM_ADDR_O  <= OP_ADDR_I;
      MEM_WDATA_O <= OP_WDATA_I;
    end
  end

  // Phase three to five outputs, plus busy flags from phase two on; read data sampled at the core edge
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      MEM_RD_O    <= '0;
      MEM_WR_O    <= '0;
      WB5_WE_O    <= '0;
      WB5_WA_O    <= '0;
      WB5_WD_O    <= '0;
      BR_TARGET_O <= 1'b0;
      BUSY_O      <= '0;
    end else begin
      MEM_RD_O    <= mem_rd_nxt;
      MEM_WR_O    <= mem_wr_nxt;
      WB5_WE_O    <= wb5_we_nxt;
      WB5_WA_O    <= wb5_wa_nxt;
      WB5_WD_O    <= MEM_RDATA_I;
      BR_TARGET_O <= br_target_nxt;
      BUSY_O      <= busy_nxt;
    end
  end
endmodule // exec_timing_ctrl

// file: rtl/exec_timing_pkg.sv
// Purpose: Shared constants and types for the execute-stage timing control
// Assumes: Two issue slots per execute group, 32 registers, 32-bit data
// Notes:   Phase indices count from the first execute phase as zero
package exec_timing_pkg;
  localparam int NSLOT    = 2;
  localparam int RW       = 5;
  localparam int NREG     = 32;
  localparam int AW       = 32;
  localparam int DW       = 32;
  localparam int NSTG     = 4;
  localparam int PH_ONE   = 0;
  localparam int PH_TWO   = 1;
  localparam int PH_THREE = 2;
  localparam int PH_FOUR  = 3;
  localparam int BR_CW    = 3;

  // Delay slots between a branch's first phase and its target's first phase, which comes six cycles after it
  localparam logic [BR_CW-1:0] BR_DELAY_SLOTS = 3'h5;
  localparam logic [BR_CW-1:0] BR_CNT_ZERO    = 3'h0;
  localparam logic [BR_CW-1:0] BR_CNT_STEP    = 3'h1;

  typedef enum logic [2:0] {
    CLS_NOP    = 3'b000,
    CLS_SINGLE = 3'b001,
    CLS_MULT   = 3'b010,
    CLS_STORE  = 3'b011,
    CLS_LOAD   = 3'b100,
    CLS_BRANCH = 3'b101
  } instr_class_t;

  typedef enum logic {
    BR_IDLE  = 1'b0,
    BR_DELAY = 1'b1
  } br_state_t;
endpackage
